// File: rtl/tpce_tx_channel.sv
// one transmit channel: parity check, 8b/10b encoder, lsb-first shifter
// assumes: host logic on hclk presents a character when tx_char_take is high
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps

// Notes on behaviour
// RULE1 - an odd-parity bit travels with every character, in every mode
// RULE2 - parity select low disables all checking, reporting and substitution
// RULE3 - select mid with encoder on checks only data bits and parity bit
// RULE4 - select high encoded, or mid bypassed, checks data, control, parity
// RULE5 - checked bits are xored; parity is valid only when the xor is one
// RULE6 - encoded mode parity failure sends violation code at current disparity
// RULE7 - bypass mode parity failure sends the positive violation form
// RULE8 - that bypass replacement is the fixed pattern 1001111000
// RULE9 - every parity error shows on the channel's own error output; here not in self-test nor during an atomic word sync run
// RULE10 - parity bit is captured always; only parity select governs its use
// RULE11 - while phase-align buffer error exists, violation code replaces input
// RULE12 - self-test sends successive characters of a 511-long sequence
// RULE13 - K28.5 is sent singly as fill or as 16-long word sync
// RULE14 - encoder on: data or special 8b/10b coding by control and select
// RULE15 - two non-overlapping special-code tables map to the same specials
// RULE16 - each 10-bit character is shifted out least significant bit first
// RULE17 - two static three-level mode inputs give nine modes
// RULE18 - bypass, test, atomic and interruptible groups; select picks meaning
// RULE19 - parity is judged in the same cycle the character is encoded
module tpce_tx_channel #(
  parameter int CHAR_DIV = tpce_pkg::CHAR_BITS
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire tpce_pkg::tpce_char_t tx_char_in,
  input  wire logic                 pa_buffer_error,
  output logic                      tx_char_take,
  output logic [9:0]                tx_code_out,
  output logic                      tx_serial_out,
  output logic                      tx_channel_error_flag,
  output logic                      irq
);
  import tpce_pkg::*;

  // ----------------------------------------------------------------------
  // 8b/10b coding; codes written abcdei / fghj with a leftmost
  // ----------------------------------------------------------------------
  localparam logic [5:0] CODE6 [32] = '{
    6'b100111, 6'b011101, 6'b101101, 6'b110001, 6'b110101, 6'b101001,
    6'b011001, 6'b111000, 6'b111001, 6'b100101, 6'b010101, 6'b110100,
    6'b001101, 6'b101100, 6'b011100, 6'b010111, 6'b011011, 6'b100011,
    6'b010011, 6'b110010, 6'b001011, 6'b101010, 6'b011010, 6'b111010,
    6'b110011, 6'b100110, 6'b010110, 6'b110110, 6'b001110, 6'b101110,
    6'b011110, 6'b101011
  };
  localparam logic [3:0] CODE4 [8] = '{
    4'b1011, 4'b1001, 4'b0101, 4'b1100, 4'b1101, 4'b1010, 4'b0110, 4'b1110
  };

  // returns {running disparity after, code with a in bit 0, i in bit 5}
  function automatic logic [10:0] enc8b10b(input logic [7:0] d,
                                           input logic k,
                                           input logic rd);
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] s6;
    logic [3:0] s4;
    logic       rd6;
    logic       alt;
    logic       k28;
    logic [9:0] c;
    x   = d[4:0];
    y   = d[7:5];
    k28 = k && (x == 5'd28);
    s6  = k28 ? 6'b001111 : CODE6[x];
    rd6 = ($countones(s6) != 3) ? !rd : rd;
    if (rd && (($countones(s6) != 3) || (x == 5'd7))) begin
      s6 = ~s6;
    end
    alt = (y == 3'd7) && (k || (!rd6 && (x == 5'd17 || x == 5'd18 ||
          x == 5'd20)) || (rd6 && (x == 5'd11 || x == 5'd13 ||
          x == 5'd14)));
    s4 = alt ? 4'b0111 : CODE4[y];
    // k28 balanced tails use the opposite form to d.x.y
    if (rd6 ? (($countones(s4) != 2) || (y == 3'd3))
            : (k28 && ($countones(s4) == 2) && (y != 3'd3))) begin
      s4 = ~s4;
    end
    for (int i = 0; i < 6; i++) begin
      c[i] = s6[5 - i];
    end
    for (int i = 0; i < 4; i++) begin
      c[6 + i] = s4[3 - i];
    end
    return {(($countones(s4) != 2) ? !rd6 : rd6), c};
  endfunction

  function automatic logic [4:0] ktail(input logic [1:0] n);
    logic [4:0] x;
    x = 5'd23;
    case (n)
      2'd0: x = 5'd23;
      2'd1: x = 5'd27;
      2'd2: x = 5'd29;
      2'd3: x = 5'd30;
      default: x = 5'd23;
    endcase
    return x;
  endfunction

  // ----------------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_reg;
  logic [STAT_W-1:0] status_reg;
  logic [STAT_W-1:0] status_next;
  logic [STAT_W-1:0] mask_reg;
  logic [7:0]        dph_addr_reg;
  logic              dph_write_reg;
  logic              dph_read_reg;
  logic [7:0]        div_reg;
  logic [4:0]        ws_cnt_reg;
  logic [4:0]        ws_cnt_next;
  logic              rd_reg;
  logic              rd_next;
  logic [8:0]        lfsr_reg;
  logic [9:0]        code_reg;
  logic [9:0]        code_next;
  logic [9:0]        shift_reg;
  logic              err_reg;
  tpce_kind_t        kind;

  // ----------------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------------------------------------
  wire       ahb_take  = hsel & htrans[1] & hready;
  wire       wr_ctrl   = dph_write_reg & (dph_addr_reg == OFS_CTRL);
  wire       wr_status = dph_write_reg & (dph_addr_reg == OFS_STATUS);
  wire       wr_mask   = dph_write_reg & (dph_addr_reg == OFS_MASK);
  wire [31:0] state_word = {15'h0000, rd_reg, err_reg, ws_cnt_reg, code_reg};
  wire [31:0] rd_mux =
      (dph_addr_reg == OFS_CTRL)   ? {25'h000_0000, ctrl_reg}   :
      (dph_addr_reg == OFS_STATUS) ? {28'h000_0000, status_reg} :
      (dph_addr_reg == OFS_MASK)   ? {28'h000_0000, mask_reg}   :
      (dph_addr_reg == OFS_STATE)  ? state_word : 32'h0000_0000;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // read data follows the latched address, so a write just before is seen
  assign hrdata    = dph_read_reg ? rd_mux : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_addr_reg  <= 8'h00;
      dph_write_reg <= 1'b0;
      dph_read_reg  <= 1'b0;
    end else if (hready) begin
      dph_addr_reg  <= haddr[7:0];
      dph_write_reg <= ahb_take & hwrite;
      dph_read_reg  <= ahb_take & !hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CTRL_RESET;
      mask_reg <= MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= hwdata[CTRL_W-1:0];
      end
      if (wr_mask) begin
        mask_reg <= hwdata[STAT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  wire [1:0] parity_check_select = ctrl_reg[CTRL_PAR_LSB +: 2];
  wire [3:0] tx_mode_select      = ctrl_reg[CTRL_MODE_LSB +: 4];
  wire [1:0] mode_hi    = tx_mode_select[3:2];               // RULE17
  wire [1:0] mode_lo    = tx_mode_select[1:0];
  wire       bist_en    = ctrl_reg[CTRL_BIST_BIT];
  wire       encoder_on = (mode_hi != LVL_LOW);               // RULE18
  wire       atomic     = (mode_hi == LVL_MID);               // RULE18

  // ----------------------------------------------------------------------
  // parity check, on the undelayed character
  // ----------------------------------------------------------------------
  wire [7:0] d   = tx_char_in.tx_char_data;
  wire [1:0] ct  = tx_char_in.tx_char_control;
  wire       sc  = tx_char_in.special_char_select;
  wire       opb = tx_char_in.tx_odd_parity_bit;        // RULE1 RULE10
  wire par_data_only = (parity_check_select == LVL_MID) & encoder_on; // RULE3
  wire par_xor  = par_data_only ? ^{d, opb} : ^{d, ct, opb};   // RULE4
  wire par_on   = (parity_check_select != LVL_LOW);            // RULE2
  wire par_fail = par_on & !par_xor;                        // RULE5 RULE19

  // ----------------------------------------------------------------------
  // character classification
  // ----------------------------------------------------------------------
  wire ws_req   = (mode_lo == LVL_MID) ? (sc & ct[0]) :
                  (ct == 2'b11);                              // RULE18
  wire fill_req = (mode_lo != LVL_HIGH) & !sc & (ct == 2'b01);
  wire spc_req  = (mode_lo == LVL_LOW)  ? (sc & (ct == 2'b01)) :
                  (mode_lo == LVL_MID)  ? (!sc & (ct == 2'b11)) :
                  (ct == 2'b01);
  wire ws_active = (ws_cnt_reg != 5'h00);
  // atomic run ignores the input; interruptible needs clean 00 characters
  wire ws_cont   = ws_active & (atomic | ((ct == 2'b00) & !par_fail));
  wire par_err_seen = par_fail & encoder_on & !bist_en & !pa_buffer_error &
                      !(ws_active & atomic) |
                      par_fail & !encoder_on & !pa_buffer_error & !bist_en;

  always_comb begin
    kind = KIND_DATA;
    if (pa_buffer_error) begin
      kind = KIND_SVS;                                          // RULE11
    end else if (bist_en) begin
      kind = KIND_BIST;                                         // RULE12
    end else if (!encoder_on) begin
      kind = par_fail ? KIND_SVS : KIND_BYPASS;                 // RULE7
    end else if (ws_cont) begin
      kind = KIND_WSYNC;                                        // RULE13
    end else if (par_fail) begin
      kind = KIND_SVS;                                          // RULE6
    end else if (ws_req) begin
      kind = KIND_WSYNC;
    end else if (fill_req) begin
      kind = KIND_FILL;                                         // RULE13
    end else if (spc_req) begin
      kind = KIND_SPECIAL;
    end
  end

  // two special-code tables: small indices, or raw k-character bytes
  wire       t1_hit  = (d <= SPC_T1_MAX);                       // RULE15
  wire [7:0] t1_byte = d[3] ? {3'h7, ktail(d[1:0])} : {d[2:0], 5'd28};
  wire       t2_hit  = (d[4:0] == 5'd28) | ((d[7:5] == 3'h7) &
                       ((d[4:0] == 5'd23) | (d[4:0] == 5'd27) |
                        (d[4:0] == 5'd29) | (d[4:0] == 5'd30)));
  wire       spc_ok  = (t1_hit | t2_hit) & (d != SPC_SVS);
  wire [7:0] spc_byte = t1_hit ? t1_byte : d;

  // ----------------------------------------------------------------------
  // encoder
  // ----------------------------------------------------------------------
  wire       is_k     = (kind == KIND_WSYNC) | (kind == KIND_FILL) |
                        (kind == KIND_SPECIAL);
  wire [7:0] enc_byte = (kind == KIND_BIST)    ? lfsr_reg[7:0] :
                        (kind == KIND_SPECIAL) ? spc_byte :
                        is_k                   ? K28_5_BYTE : d;
  wire [10:0] enc_res = enc8b10b(enc_byte, is_k, rd_reg);     // RULE14
  wire        use_svs = (kind == KIND_SVS) |
                        ((kind == KIND_SPECIAL) & !spc_ok);
  // balanced violation code: disparity unchanged either way
  wire [9:0]  svs_code = (encoder_on & rd_reg) ? SVS_NEG : SVS_POS; // RULE8

  always_comb begin
    code_next = enc_res[9:0];
    rd_next   = enc_res[10];
    if (use_svs) begin
      code_next = svs_code;                                     // RULE6
      rd_next   = rd_reg;
    end else if (kind == KIND_BYPASS) begin
      code_next = {ct, d};
      rd_next   = rd_reg;
    end
  end

  always_comb begin
    ws_cnt_next = 5'h00;
    if (kind == KIND_WSYNC) begin
      ws_cnt_next = ws_cont ? ws_cnt_reg - 5'h01 : WS_LEN - 5'h01; // RULE13
    end
  end

  // ----------------------------------------------------------------------
  // character rate and shifter
  // ----------------------------------------------------------------------
  wire char_tick = (div_reg == 8'(CHAR_DIV - 1));
  wire bist_wrap = char_tick & bist_en & (lfsr_reg == BIST_SEED);
  assign tx_char_take          = char_tick;
  assign tx_code_out           = code_reg;
  assign tx_serial_out         = shift_reg[0];                  // RULE16
  assign tx_channel_error_flag = err_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= char_tick ? 8'h00 : div_reg + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_reg   <= SVS_POS;
      shift_reg  <= SVS_POS;
      rd_reg     <= 1'b0;
      ws_cnt_reg <= 5'h00;
      err_reg    <= 1'b0;
    end else if (char_tick) begin
      code_reg   <= code_next;
      shift_reg  <= code_next;
      rd_reg     <= rd_next;
      ws_cnt_reg <= ws_cnt_next;
      err_reg    <= par_err_seen | pa_buffer_error;             // RULE9
    end else begin
      shift_reg  <= {1'b0, shift_reg[9:1]};                     // RULE16
    end
  end

  // x^9 + x^5 + 1 runs through 511 states before repeating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lfsr_reg <= BIST_SEED;
    end else if (!bist_en) begin
      lfsr_reg <= BIST_SEED;
    end else if (char_tick) begin
      lfsr_reg <= {lfsr_reg[7:0], lfsr_reg[8] ^ lfsr_reg[4]};   // RULE12
    end
  end

  // ----------------------------------------------------------------------
  // sticky status, write one to clear; a new event beats the clear
  // ----------------------------------------------------------------------
  wire [STAT_W-1:0] ev;
  assign ev[STAT_PAR_BIT]  = char_tick & par_err_seen;          // RULE9
  assign ev[STAT_PA_BIT]   = char_tick & pa_buffer_error;
  assign ev[STAT_WS_BIT]   = char_tick & (kind == KIND_WSYNC) & !ws_cont;
  assign ev[STAT_BIST_BIT] = bist_wrap;
  wire [STAT_W-1:0] clr = wr_status ? hwdata[STAT_W-1:0] : STAT_RESET;
  assign status_next = (status_reg & ~clr) | ev;
  assign irq         = |(status_reg & mask_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= STAT_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

endmodule

// File: rtl/tpce_pkg.sv
// constants, types and register map of the transmit parity check / encoder
// assumes: one 100 MHz clock, registers reached over ahb-lite
package tpce_pkg;

  // ----------------------------------------------------------------------
  // three-level selector codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_MID  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_STATE  = 8'h0C;

  localparam int CTRL_PAR_LSB     = 0;
  localparam int CTRL_MODE_LSB    = 2;
  localparam int CTRL_BIST_BIT    = 6;
  localparam int CTRL_W           = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  localparam int STAT_PAR_BIT  = 0;
  localparam int STAT_PA_BIT   = 1;
  localparam int STAT_WS_BIT   = 2;
  localparam int STAT_BIST_BIT = 3;
  localparam int STAT_W        = 4;
  localparam logic [3:0] STAT_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  localparam int STATE_RD_BIT  = 16;
  localparam int STATE_ERR_BIT = 15;
  localparam int STATE_WS_LSB  = 10;

  // ----------------------------------------------------------------------
  // character timing and codes
  // ----------------------------------------------------------------------
  localparam int          CHAR_BITS  = 10;
  localparam logic [4:0]  WS_LEN     = 5'h10;
  localparam logic [9:0]  SVS_POS    = 10'h079;
  localparam logic [9:0]  SVS_NEG    = 10'h386;
  localparam logic [7:0]  K28_5_BYTE = 8'hBC;
  localparam logic [7:0]  SPC_SVS    = 8'h0C;
  localparam logic [7:0]  SPC_T1_MAX = 8'h0B;
  localparam logic [8:0]  BIST_SEED  = 9'h1FF;

  typedef struct packed {
    logic [7:0] tx_char_data;
    logic [1:0] tx_char_control;
    logic       tx_odd_parity_bit;
    logic       special_char_select;
  } tpce_char_t;

  typedef enum logic [2:0] {
    KIND_BYPASS, KIND_SVS, KIND_BIST, KIND_WSYNC,
    KIND_FILL, KIND_SPECIAL, KIND_DATA
  } tpce_kind_t;

endpackage

// File: tb/tpce_tx_monitor.sv
// concurrent checks on one transmit channel, ports only
// assumes: bound into tpce_tx_channel; ctrl copied from ahb writes
`timescale 1ns/1ps
module tpce_tx_monitor #(
  parameter int CHAR_DIV = 10
) (
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic [31:0]          hwdata,
  input wire logic                 hready,
  input wire tpce_pkg::tpce_char_t tx_char_in,
  input wire logic                 pa_buffer_error,
  input wire logic                 tx_char_take,
  input wire logic [9:0]           tx_code_out,
  input wire logic                 tx_serial_out,
  input wire logic                 tx_channel_error_flag
);
  import tpce_pkg::*;
  // ----------------------------------------------------------------
  // shadow of ctrl, so checks know the parity set and the mode
  // ----------------------------------------------------------------
  logic       wr_ctrl_reg;
  logic [6:0] ctrl_reg;
  wire  [1:0] par_sel = ctrl_reg[1:0];
  wire        bypass  = (ctrl_reg[5:4] == LVL_LOW);
  wire        checked = (par_sel != LVL_LOW);
  wire        full    = par_sel[1] | ((par_sel == LVL_MID) & bypass);
  wire        xor_ok  = ^tx_char_in.tx_char_data
                      ^ tx_char_in.tx_odd_parity_bit
                      ^ (full & ^tx_char_in.tx_char_control);
  // pa error and self-test outrank everything, so leave them out
  wire        plain   = tx_char_take & ~pa_buffer_error
                      & ~ctrl_reg[CTRL_BIST_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctrl_reg <= 1'b0;
      ctrl_reg    <= CTRL_RESET;
    end else begin
      wr_ctrl_reg <= hsel & htrans[1] & hready & hwrite
                   & (haddr[7:0] == OFS_CTRL);
      if (wr_ctrl_reg) ctrl_reg <= hwdata[6:0];
    end
  end

  default clocking dcb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_take_period: assert property (
    tx_char_take |=> (!tx_char_take) [*8] ##2 tx_char_take)
    else $error("take pulse spacing wrong");
  chk_serial_lsb: assert property (
    tx_char_take |=> (tx_serial_out == tx_code_out[0])
      ##5 (tx_serial_out == tx_code_out[5])
      ##4 (tx_serial_out == tx_code_out[9]))
    else $error("serial bit order wrong");
  chk_code_stands: assert property (
    !tx_char_take |=> $stable(tx_code_out)
      && $stable(tx_channel_error_flag))
    else $error("code changed between takes");
  chk_pa_violation: assert property (
    tx_char_take && pa_buffer_error |=> tx_channel_error_flag
      && (tx_code_out == SVS_POS || tx_code_out == SVS_NEG))
    else $error("buffer error not replaced");
  chk_par_off: assert property (
    plain && !checked |=> !tx_channel_error_flag)
    else $error("flag with checking off");
  chk_bypass_bad: assert property (
    plain && bypass && checked && !xor_ok |=>
      tx_code_out == SVS_POS && tx_channel_error_flag)
    else $error("bypass parity failure not replaced");
  chk_bypass_pass: assert property (
    plain && bypass && (!checked || xor_ok) |=> !tx_channel_error_flag
      && tx_code_out == $past({tx_char_in.tx_char_control,
                               tx_char_in.tx_char_data}))
    else $error("bypass character altered");
  chk_enc_mid_set: assert property (
    plain && !bypass && par_sel == LVL_MID && xor_ok
      |=> !tx_channel_error_flag)
    else $error("control bits entered data-only check");
  chk_flag_cause: assert property (
    $rose(tx_channel_error_flag) |-> $past(tx_char_take))
    else $error("flag rose without a take");
endmodule

// File: tb/tpce_host_model.sv
// host logic model: presents one character and holds it until taken
// assumes: take pulse from the channel; bench calls send
`timescale 1ns/1ps
module tpce_host_model (
  input  wire logic           hclk,
  input  wire logic           tx_char_take,
  output tpce_pkg::tpce_char_t char_out
);
  import tpce_pkg::*;
  // idle fill is D0.0 with odd parity right for every check set
  localparam tpce_char_t IDLE = '{8'h00, 2'b00, 1'b1, 1'b0};

  initial char_out = IDLE;

  task automatic send(input tpce_char_t c);
    @(posedge hclk);
    char_out <= c;
    forever begin
      @(negedge hclk);
      if (tx_char_take === 1'b1) break;
    end
    @(posedge hclk);
    // the character only stands up to the taking edge
    char_out <= IDLE;
  endtask
endmodule

// File: tb/tpce_tx_channel_bench.sv
// self-checking bench for one transmit channel
// assumes: host model on the character side, bench is the ahb master
`timescale 1ns/1ps
module tpce_tx_channel_bench;
  import tpce_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, pa_buffer_error;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, tx_char_take, tx_serial_out, irq;
  logic        tx_channel_error_flag;
  logic [9:0]  tx_code_out;
  tpce_char_t  tx_char_in;
  int          miscompares, n_tests;

  tpce_tx_channel u_tpce_tx_channel (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tx_char_in(tx_char_in), .pa_buffer_error(pa_buffer_error),
    .tx_char_take(tx_char_take), .tx_code_out(tx_code_out),
    .tx_serial_out(tx_serial_out),
    .tx_channel_error_flag(tx_channel_error_flag), .irq(irq));
  tpce_host_model u_tpce_host_model (.hclk(hclk),
    .tx_char_take(tx_char_take), .char_out(tx_char_in));

  always #5 hclk = ~hclk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  function automatic tpce_char_t mk(input logic [7:0] d,
    input logic [1:0] c, input logic sc, input logic full,
    input logic good);
    mk = '{d, c, (^d) ^ (full & (^c)) ^ good, sc};
  endfunction

  task automatic close_out;
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(32'(hresp), 32'h0000_0000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0000_0000, v);
    chk(v, exp);
  endtask

  task automatic tx(input tpce_char_t c, output logic [9:0] code,
                    output logic fl);
    u_tpce_host_model.send(c);
    #1;
    code = tx_code_out;
    fl = tx_channel_error_flag;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(32'(tx_code_out), 32'(SVS_POS));
    chk(32'(irq), 32'h0000_0000);
    rdc(OFS_CTRL, 32'(CTRL_RESET));
    rdc(OFS_STATUS, 32'(STAT_RESET));
    rdc(OFS_MASK, 32'(MASK_RESET));
  endtask

  task automatic t_bypass;
    logic [9:0] code;
    logic       fl;
    logic [9:0] sb;
    tpce_char_t c;
    // data-only parity right, full parity wrong
    c = mk(8'h5A, 2'b10, 1'b0, 1'b1, 1'b0);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CTRL, 32'(s));
      tx(c, code, fl);
      chk(32'(code), s == 0 ? 32'h0000_025A : 32'(SVS_POS));
      chk(32'(fl), 32'(s != 0));
    end
    tx(mk(8'hA5, 2'b01, 1'b0, 1'b1, 1'b1), code, fl);
    chk(32'(code), 32'h0000_01A5);
    for (int i = 0; i < 10; i++) begin
      @(negedge hclk);
      sb[i] = tx_serial_out;
    end
    chk(32'(sb), 32'h0000_01A5);
  endtask

  task automatic t_encoded;
    logic [9:0]  code;
    logic        fl;
    logic [31:0] v;
    wr(OFS_CTRL, 32'h0000_0029);
    tx(mk(8'hBC, 2'b01, 1'b0, 1'b0, 1'b1), code, fl);
    chk(32'(fl), 32'h0000_0000);
    chk(32'(code), 32'h0000_017C);
    ahb(1'b0, OFS_STATE, 32'h0000_0000, v);
    chk(32'(v[STATE_RD_BIT]), 32'h0000_0001);
    tx(mk(8'h12, 2'b00, 1'b0, 1'b0, 1'b0), code, fl);
    chk(32'(code), 32'(SVS_NEG));
    chk(32'(fl), 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_002A);
    tx(mk(8'hBC, 2'b01, 1'b0, 1'b0, 1'b1), code, fl);
    chk(32'(fl), 32'h0000_0001);
  endtask

  task automatic t_wsync;
    logic [9:0] code;
    logic       fl;
    int         n;
    tpce_char_t idle;
    tpce_char_t c;
    idle = mk(8'h00, 2'b00, 1'b0, 1'b0, 1'b1);
    n = 0;
    wr(OFS_CTRL, 32'h0000_0019);
    tx(mk(8'h00, 2'b11, 1'b0, 1'b0, 1'b1), code, fl);
    for (int i = 0; i < 17; i++) begin
      n += int'(code == 10'h17C || code == 10'h283);
      // a bad character mid-run must be ignored
      c = (i == 3) ? mk(8'h01, 2'b00, 1'b0, 1'b0, 1'b0) : idle;
      tx(c, code, fl);
      if (i == 3) chk(32'(fl), 32'h0000_0000);
    end
    chk(32'(n), 32'h0000_0010);
  endtask

  task automatic t_pa_irq;
    logic [9:0] code;
    logic       fl;
    @(posedge hclk);
    pa_buffer_error <= 1'b1;
    tx(mk(8'h00, 2'b00, 1'b0, 1'b0, 1'b1), code, fl);
    chk(32'(fl), 32'h0000_0001);
    chk(32'(code == SVS_POS || code == SVS_NEG), 32'h0000_0001);
    @(posedge hclk);
    pa_buffer_error <= 1'b0;
    rdc(OFS_STATUS, 32'h0000_0007);
    chk(32'(irq), 32'h0000_0000);
    wr(OFS_MASK, 32'h0000_0002);
    #1 chk(32'(irq), 32'h0000_0001);
    wr(OFS_STATUS, 32'h0000_0002);
    #1 chk(32'(irq), 32'h0000_0000);
    rdc(OFS_STATUS, 32'h0000_0005);
    rdc(OFS_MASK, 32'h0000_0002);
    wr(8'h40, 32'hFFFF_FFFF);
    rdc(8'h40, 32'h0000_0000);
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    pa_buffer_error = 1'b0;
    miscompares = 0;
    n_tests = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_bypass;
    t_encoded;
    t_wsync;
    t_pa_irq;
    close_out;
  end

  // 27 characters plus bus traffic
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    close_out;
  end
endmodule

bind tpce_tx_channel tpce_tx_monitor #(.CHAR_DIV(CHAR_DIV)) u_tpce_tx_monitor (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .tx_char_in(tx_char_in), .pa_buffer_error(pa_buffer_error),
  .tx_char_take(tx_char_take), .tx_code_out(tx_code_out),
  .tx_serial_out(tx_serial_out),
  .tx_channel_error_flag(tx_channel_error_flag));
